// ---- core/scg_defines.vh ----
// scg_defines.vh: offsets, field positions, reset values and codes for the unit clock gate block
// assumes inclusion by bare name from design files under core/
`ifndef SCG_DEFINES_VH
`define SCG_DEFINES_VH

`define SCG_OFF_RUN_GATE        12'h100
`define SCG_OFF_SLEEP_GATE      12'h110
`define SCG_OFF_DEEP_GATE       12'h120
`define SCG_OFF_RUN_CLOCK_CFG   12'h060
`define SCG_OFF_IRQ_STATUS      12'h1f0
`define SCG_OFF_IRQ_MASK        12'h1f4
`define SCG_OFF_CLOCK_STATE     12'h1f8

`define SCG_GATE_RESET          32'h00000040
`define SCG_GATE_WMASK          32'h00010348
`define SCG_BIT_CONVERTER       16
`define SCG_BIT_RATE_LO         8
`define SCG_BIT_RATE_HI         9
`define SCG_BIT_HIBERNATION     6
`define SCG_BIT_WATCHDOG        3

`define SCG_CFG_RESET           32'h00000000
`define SCG_BIT_AUTO_GATING     27

`define SCG_RATE_125K           2'h0
`define SCG_RATE_250K           2'h1
`define SCG_RATE_500K           2'h2

`define SCG_MODE_RUN            2'h0
`define SCG_MODE_SLEEP          2'h1
`define SCG_MODE_DEEP           2'h2

`define SCG_IRQ_WIDTH           3
`define SCG_IRQ_CONV_FAULT      0
`define SCG_IRQ_WDOG_FAULT      1
`define SCG_IRQ_BAD_WRITE       2

`endif

// ---- core/scg_clock_gate.v ----
// scg_clock_gate.v: run, sleep and deep-sleep unit clock gating registers behind an apb slave,
// with clock enables, converter rate select, unit access fault checks and an interrupt.
// assumes a single clock mclk, a synchronous reset, and that the power manager reports the mode.
// the gated units decode their own addresses and raise conv_access or wdog_access;
// this block only answers whether such an access may complete.
//
// Summary of operation
// - each enable bit set clocks its unit; clear stops that unit's clock.
// - an access to the unclocked converter or watchdog answers with a bus fault.
// - gating registers reset to 0x00000040: only hibernation clocked.
// - bit 16 enables converter clock, resets zero; unclocked access faults.
// - bits 9:8 pick converter rate 125K, 250K, 500K; reset zero.
// - bit 6 enables hibernation clock, resets to one.
// - bit 3 enables watchdog clock, resets zero; unclocked access faults.
// - reserved bits are read-only and read as zero.
// - three identical gating registers: run, sleep, deep-sleep.
// - sleep registers act only while automatic gating select is set.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "scg_defines.vh"

module scg_clock_gate (
  input  wire        mclk,
  input  wire        rst,
  input  wire        clk_en,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire [1:0]  power_mode,
  input  wire        conv_access,
  input  wire        wdog_access,
  output wire        conv_access_fault,
  output wire        wdog_access_fault,
  output reg         converter_clock_enable,
  output reg         hibernation_clock_enable,
  output reg         watchdog_clock_enable,
  output reg  [1:0]  converter_rate_select,
  output wire        irq
);

  localparam [2:0] ST_IDLE   = 3'b001;
  localparam [2:0] ST_SETUP  = 3'b010;
  localparam [2:0] ST_ACCESS = 3'b100;

  reg  [31:0] run_unit_clock_gate;
  reg  [31:0] sleep_unit_clock_gate;
  reg  [31:0] deep_sleep_unit_clock_gate;
  reg  [31:0] run_clock_config;
  reg  [`SCG_IRQ_WIDTH-1:0] irq_status;
  reg  [`SCG_IRQ_WIDTH-1:0] irq_mask;
  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg  [31:0] active_gate;
  reg  [31:0] next_rdata;
  reg         addr_hit;

  wire auto_gating_select = run_clock_config[`SCG_BIT_AUTO_GATING];
  wire wr_strobe = psel & penable & pwrite & clk_en;
  wire rd_strobe = psel & penable & ~pwrite & clk_en;

  // decodes one gating register offset; used for all three copies
  function is_gate_reg;
    input [11:0] addr;
    begin
      case (addr)
        `SCG_OFF_RUN_GATE:   is_gate_reg = 1'b1;
        `SCG_OFF_SLEEP_GATE: is_gate_reg = 1'b1;
        `SCG_OFF_DEEP_GATE:  is_gate_reg = 1'b1;
        default:             is_gate_reg = 1'b0;
      endcase
    end
  endfunction

  // value written back into a gating register; reserved bits forced to zero
  function [31:0] gate_wval;
    input [31:0] data;
    begin
      gate_wval = data & `SCG_GATE_WMASK;
    end
  endfunction

  // a rate above the 500K code is beyond the converter, so such a write is flagged
  function rate_bad;
    input [31:0] data;
    begin
      case (data[`SCG_BIT_RATE_HI:`SCG_BIT_RATE_LO])
        `SCG_RATE_125K: rate_bad = 1'b0;
        `SCG_RATE_250K: rate_bad = 1'b0;
        `SCG_RATE_500K: rate_bad = 1'b0;
        default:        rate_bad = 1'b1;
      endcase
    end
  endfunction

  // apb state tracked only for protocol sanity; answer is always zero-wait
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (psel) begin
          next_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        next_state = ST_ACCESS;
      end
      ST_ACCESS: begin
        if (psel & ~penable) begin
          next_state = ST_SETUP;
        end else if (~psel) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      state <= ST_IDLE;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // unmapped offsets answer with pslverr; a write there changes nothing
  always @* begin
    if (is_gate_reg(paddr)) begin
      addr_hit = 1'b1;
    end else begin
      case (paddr)
        `SCG_OFF_RUN_CLOCK_CFG: addr_hit = 1'b1;
        `SCG_OFF_IRQ_STATUS:    addr_hit = 1'b1;
        `SCG_OFF_IRQ_MASK:      addr_hit = 1'b1;
        `SCG_OFF_CLOCK_STATE:   addr_hit = 1'b1;
        default:                addr_hit = 1'b0;
      endcase
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;

  // three copies of the same layout; one strobe per register keeps each process small
  // and lets a write reach exactly one copy
  wire wr_run_gate   = wr_strobe & (paddr == `SCG_OFF_RUN_GATE);
  wire wr_sleep_gate = wr_strobe & (paddr == `SCG_OFF_SLEEP_GATE);
  wire wr_deep_gate  = wr_strobe & (paddr == `SCG_OFF_DEEP_GATE);
  wire wr_run_cfg    = wr_strobe & (paddr == `SCG_OFF_RUN_CLOCK_CFG);
  wire wr_irq_mask   = wr_strobe & (paddr == `SCG_OFF_IRQ_MASK);

  always @(posedge mclk) begin
    if (rst) begin
      run_unit_clock_gate <= `SCG_GATE_RESET;
    end else if (wr_run_gate) begin
      run_unit_clock_gate <= gate_wval(pwdata);
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      sleep_unit_clock_gate <= `SCG_GATE_RESET;
    end else if (wr_sleep_gate) begin
      sleep_unit_clock_gate <= gate_wval(pwdata);
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      deep_sleep_unit_clock_gate <= `SCG_GATE_RESET;
    end else if (wr_deep_gate) begin
      deep_sleep_unit_clock_gate <= gate_wval(pwdata);
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      run_clock_config <= `SCG_CFG_RESET;
    end else if (wr_run_cfg) begin
      run_clock_config <= pwdata & (32'h1 << `SCG_BIT_AUTO_GATING);
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      irq_mask <= {`SCG_IRQ_WIDTH{1'b0}};
    end else if (wr_irq_mask) begin
      irq_mask <= pwdata[`SCG_IRQ_WIDTH-1:0];
    end
  end

  // mode select; sleep copies only count while automatic gating is on
  always @* begin
    active_gate = run_unit_clock_gate;
    case (power_mode)
      `SCG_MODE_SLEEP: begin
        if (auto_gating_select) begin
          active_gate = sleep_unit_clock_gate;
        end
      end
      `SCG_MODE_DEEP: begin
        if (auto_gating_select) begin
          active_gate = deep_sleep_unit_clock_gate;
        end
      end
      default: begin
        active_gate = run_unit_clock_gate;
      end
    endcase
  end

  // registered enables so downstream clock gate cells see glitch-free levels
  always @(posedge mclk) begin
    if (rst) begin
      converter_clock_enable <= 1'b0;
    end else if (clk_en) begin
      converter_clock_enable <= active_gate[`SCG_BIT_CONVERTER];
    end
  end

  // hibernation is clocked from reset so its wake logic keeps running
  always @(posedge mclk) begin
    if (rst) begin
      hibernation_clock_enable <= 1'b1;
    end else if (clk_en) begin
      hibernation_clock_enable <= active_gate[`SCG_BIT_HIBERNATION];
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      watchdog_clock_enable <= 1'b0;
    end else if (clk_en) begin
      watchdog_clock_enable <= active_gate[`SCG_BIT_WATCHDOG];
    end
  end

  // the rate goes out even while the converter is gated, so it is ready at restart
  always @(posedge mclk) begin
    if (rst) begin
      converter_rate_select <= `SCG_RATE_125K;
    end else if (clk_en) begin
      converter_rate_select <= active_gate[`SCG_BIT_RATE_HI:`SCG_BIT_RATE_LO];
    end
  end

  // faults look at the registered enables, the same level the gated units see
  localparam integer UNIT_CONV = 0;
  localparam integer UNIT_WDOG = 1;
  wire [1:0] unit_access = {wdog_access, conv_access};
  wire [1:0] unit_enable = {watchdog_clock_enable, converter_clock_enable};
  wire [1:0] unit_fault;
  genvar ui;
  generate
    for (ui = 0; ui < 2; ui = ui + 1) begin : g_fault
      assign unit_fault[ui] = unit_access[ui] & ~unit_enable[ui];
    end
  endgenerate
  assign conv_access_fault = unit_fault[UNIT_CONV];
  assign wdog_access_fault = unit_fault[UNIT_WDOG];

  // sticky events; a new event in the clear cycle stays set
  wire [`SCG_IRQ_WIDTH-1:0] irq_event;
  assign irq_event[`SCG_IRQ_CONV_FAULT] = conv_access_fault;
  assign irq_event[`SCG_IRQ_WDOG_FAULT] = wdog_access_fault;
  assign irq_event[`SCG_IRQ_BAD_WRITE]  = wr_strobe & is_gate_reg(paddr) & rate_bad(pwdata);

  wire status_clr = wr_strobe & (paddr == `SCG_OFF_IRQ_STATUS);
  // write-one-to-clear mask per bit; the set term is tested first so a clash keeps the bit
  wire [`SCG_IRQ_WIDTH-1:0] irq_clr = {`SCG_IRQ_WIDTH{status_clr}} & pwdata[`SCG_IRQ_WIDTH-1:0];

  genvar gi;
  generate
    for (gi = 0; gi < `SCG_IRQ_WIDTH; gi = gi + 1) begin : g_irq
      always @(posedge mclk) begin
        if (rst) begin
          irq_status[gi] <= 1'b0;
        end else if (clk_en) begin
          if (irq_event[gi]) begin
            irq_status[gi] <= 1'b1;
          end else if (irq_clr[gi]) begin
            irq_status[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // level output; stays high until software clears the status bit or masks it
  assign irq = |(irq_status & irq_mask);

  // reserved bits of every register read as zero
  always @* begin
    next_rdata = 32'h0;
    case (paddr)
      `SCG_OFF_RUN_GATE: begin
        next_rdata = run_unit_clock_gate;
      end
      `SCG_OFF_SLEEP_GATE: begin
        next_rdata = sleep_unit_clock_gate;
      end
      `SCG_OFF_DEEP_GATE: begin
        next_rdata = deep_sleep_unit_clock_gate;
      end
      `SCG_OFF_RUN_CLOCK_CFG: begin
        next_rdata = run_clock_config;
      end
      `SCG_OFF_IRQ_STATUS: begin
        next_rdata = {29'h0, irq_status};
      end
      `SCG_OFF_IRQ_MASK: begin
        next_rdata = {29'h0, irq_mask};
      end
      `SCG_OFF_CLOCK_STATE: begin
        next_rdata = {15'h0, converter_clock_enable, 6'h0,
                      converter_rate_select, 1'b0,
                      hibernation_clock_enable, 2'h0,
                      watchdog_clock_enable, 3'h0};
      end
      default: begin
        next_rdata = 32'h0;
      end
    endcase
  end

  // prdata is registered at the setup cycle, so it is valid in the access phase
  always @(posedge mclk) begin
    if (rst) begin
      prdata <= 32'h0;
    end else if (clk_en & psel & ~penable & ~pwrite) begin
      prdata <= next_rdata;
    end else if (rd_strobe) begin
      prdata <= prdata;
    end
  end

endmodule // scg_clock_gate

// ---- test/scg_clock_gate_sva.sv ----
// checker for scg_clock_gate: port relations of gating, faults, reset and readback
// assumes one clock mclk and the synchronous active-high reset of the design
`timescale 1ns/1ps
module scg_chk (
  input logic        mclk,
  input logic        rst,
  input logic        clk_en,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic        pready,
  input logic [31:0] prdata,
  input logic        pslverr,
  input logic [1:0]  power_mode,
  input logic        conv_access,
  input logic        wdog_access,
  input logic        conv_access_fault,
  input logic        wdog_access_fault,
  input logic        converter_clock_enable,
  input logic        hibernation_clock_enable,
  input logic        watchdog_clock_enable,
  input logic [1:0]  converter_rate_select,
  input logic        irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire rd_acc = psel && penable && !pwrite;
  // only run-mode writes are checked: sleep copies depend on hidden config
  wire wr_run = psel && penable && pwrite && clk_en && paddr == 12'h100 && power_mode == 2'h0;
  chk_conv_fault: assert property (conv_access_fault == (conv_access && !converter_clock_enable))
    else $error("converter fault mismatch");
  chk_wdog_fault: assert property (wdog_access_fault == (watchdog_clock_enable ? 1'b0 : wdog_access))
    else $error("watchdog fault mismatch");
  chk_reset_vals: assert property ($fell(rst) |-> hibernation_clock_enable && !converter_clock_enable
    && !watchdog_clock_enable && converter_rate_select == 2'h0) else $error("bad reset values");
  chk_reset_irq: assert property ($fell(rst) |-> !irq) else $error("irq after reset");
  chk_rsvd_sleep: assert property (rd_acc && paddr == 12'h110 |-> (prdata & 32'hfffefcb7) == 0)
    else $error("reserved bits set");
  chk_rsvd_other: assert property (rd_acc && (paddr == 12'h100 || paddr == 12'h120)
    |-> (prdata & 32'hfffefcb7) == 0) else $error("reserved bits set");
  chk_run_apply: assert property (wr_run ##1 (clk_en && power_mode == 2'h0) |=>
    {converter_clock_enable, hibernation_clock_enable, watchdog_clock_enable}
    == {$past(pwdata[16], 2), $past(pwdata[6], 2), $past(pwdata[3], 2)}) else $error("enables wrong");
  chk_rate_apply: assert property (wr_run ##1 (clk_en && power_mode == 2'h0) |=>
    converter_rate_select == $past(pwdata[9:8], 2)) else $error("rate wrong");
  chk_freeze: assert property (!clk_en |=> $stable({converter_clock_enable, watchdog_clock_enable,
    hibernation_clock_enable, converter_rate_select})) else $error("enables moved while frozen");
endmodule // scg_chk
bind scg_clock_gate scg_chk u_chk (.*);

// ---- test/scg_clock_gate_tb.sv ----
// self-checking bench for scg_clock_gate: register table, enables, faults, irq
// assumes the zero-wait apb slave and the 20 MHz mclk of the design
`timescale 1ns/1ps
module scg_clock_gate_tb;
  logic        mclk = 0, rst = 1, clk_en = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic [1:0]  power_mode = 0;
  logic        conv_access = 0, wdog_access = 0;
  wire         pready, pslverr, conv_access_fault, wdog_access_fault, irq;
  wire         converter_clock_enable, hibernation_clock_enable, watchdog_clock_enable;
  wire [1:0]   converter_rate_select;
  wire [31:0]  prdata;
  int          error_cnt = 0, comparisons = 0, cyc = 0;
  logic [75:0] rows [4] = '{{12'h110, 32'hffffffff, 32'h00010348},
    {12'h110, 32'h00000200, 32'h00000200}, {12'h120, 32'hfffeffff, 32'h00000348},
    {12'h100, 32'h00010148, 32'h00010148}};
  always #25 mclk = ~mclk;
  scg_clock_gate u_dut (.*);
  always @(posedge mclk) if (++cyc > 2000) begin
    error_cnt++;
    $display("MISMATCH %0t timeout", $time);
    tally_and_finish;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge mclk) penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // enables land one edge after the write, so wait two before looking
  task pins(input logic [4:0] e);
    repeat (2) @(posedge mclk);
    #1 chk({27'h0, converter_clock_enable, hibernation_clock_enable, watchdog_clock_enable,
      converter_rate_select}, {27'h0, e});
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 0;
    foreach (rows[i]) begin
      apb(1, rows[i][75:64], rows[i][63:32]);
      apb(0, rows[i][75:64], 0);
      chk(rd, rows[i][31:0]);
    end
    pins(5'b11101);
    $display("table done");
    apb(1, 12'h100, 0);
    pins(5'b00000);
    @(posedge mclk) {conv_access, wdog_access} <= 2'b11;
    pins(5'b00000);
    chk({30'h0, conv_access_fault, wdog_access_fault}, 3);
    chk({31'h0, irq}, 0);
    apb(1, 12'h100, 32'h00010048);
    pins(5'b11100);
    chk({30'h0, conv_access_fault, wdog_access_fault}, 0);
    @(posedge mclk) {conv_access, wdog_access} <= 2'b00;
    apb(1, 12'h1f4, 3);
    pins(5'b11100);
    chk({31'h0, irq}, 1);
    apb(1, 12'h1f0, 3);
    pins(5'b11100);
    chk({31'h0, irq}, 0);
    apb(0, 12'h1f0, 0);
    chk(rd, 32'h00000004);
    $display("faults done");
    @(posedge mclk) power_mode <= 1;
    pins(5'b11100);
    apb(1, 12'h060, 32'h08000000);
    pins(5'b00010);
    @(posedge mclk) power_mode <= 2;
    pins(5'b01111);
    apb(0, 12'h1f8, 0);
    chk(rd, 32'h00000348);
    @(posedge mclk) {power_mode, clk_en} <= 3'b000;
    apb(1, 12'h100, 0);
    clk_en <= 1;
    apb(0, 12'h100, 0);
    chk(rd, 32'h00010048);
    apb(0, 12'h3fc, 0);
    chk({31'h0, err}, 1);
    chk(rd, 0);
    $display("modes done");
    @(posedge mclk) rst <= 1;
    repeat (2) @(posedge mclk);
    rst <= 0;
    pins(5'b01000);
    foreach (rows[i]) begin
      apb(0, rows[i][75:64], 0);
      chk(rd, 32'h00000040);
    end
    $display("reset done");
    tally_and_finish;
  end
endmodule // scg_clock_gate_tb
